// ==== core/gdsfc_pkg.sv ====
// shared constants for the gate driver state, fault and serial control core
`default_nettype none
package gdsfc_pkg;
	// serial frame layout
	localparam int FRAME_BITS   = 16;
	localparam int CNT_W        = 5;
	localparam int TOP_BIT      = 15;
	localparam int RW_BIT       = 14;
	localparam int ADDR_HI      = 13;
	localparam int ADDR_LO      = 8;
	localparam int DATA_HI      = 7;
	localparam logic [4:0] CNT_FULL = 5'h10;
	localparam logic [4:0] CNT_OVER = 5'h11;
	// register addresses and bit positions
	localparam logic [5:0] ADDR_STAT1 = 6'h00;
	localparam logic [5:0] ADDR_STAT2 = 6'h02;
	localparam logic [5:0] ADDR_CTRL  = 6'h04;
	localparam int CTRL_EN_BIT  = 7;
	localparam int CTRL_CLR_BIT = 0;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// wake delay
	localparam int WAKE_US      = 1;
	localparam int CLK_MHZ      = 100;
	localparam int WAKE_CYC     = WAKE_US * CLK_MHZ;
	localparam logic [7:0] WAKE_CNT = 8'(WAKE_CYC);
	// monitor response modes
	typedef enum logic [1:0] {
		GDSFC_LATCHED,
		GDSFC_CYCLE,
		GDSFC_WARN,
		GDSFC_DISABLED
	} gdsfc_mode_t;
	typedef enum logic [1:0] {
		GDSFC_SLEEP,
		GDSFC_WAKE,
		GDSFC_STANDBY,
		GDSFC_OPERATE
	} gdsfc_state_t;
endpackage : gdsfc_pkg
`default_nettype wire

// ==== core/gdsfc_spi_link.sv ====
// serial slave shift logic running on the link clock
`timescale 1ns/1ns
`default_nettype none
module gdsfc_spi_link (
	// link pins
	input  wire logic        i_sclk,
	input  wire logic        i_chip_select_n,
	input  wire logic        i_sdi,
	output logic             o_sdo,
	output logic             o_sdo_oe,
	// reply word, held stable by the core during a frame
	input  wire logic [15:0] i_reply,
	// captured frame and its bit count, stable after select rises
	output logic [15:0]      o_word,
	output logic [4:0]       o_count,
	output logic             o_done_tgl
);
	logic [15:0] shin_reg;
	logic [15:0] shin_next;
	logic [4:0]  cnt_reg;
	logic [4:0]  cnt_next;
	logic [15:0] shout_reg;
	logic [15:0] shout_next;

	// capture: count restarts with every frame, saturates above sixteen
	always_comb begin
		shin_next = {shin_reg[14:0], i_sdi};
		cnt_next  = (cnt_reg == gdsfc_pkg::CNT_OVER) ? cnt_reg
			: cnt_reg + 5'h01;
	end

	always_ff @(negedge i_sclk or posedge i_chip_select_n) begin
		if (i_chip_select_n) begin
			cnt_reg  <= 5'h00;
		end else begin
			shin_reg <= shin_next;
			cnt_reg  <= cnt_next;
		end
	end

	// launch: next bit moves up on each rising edge
	always_comb begin
		shout_next = {shout_reg[14:0], 1'b0};
	end

	always_ff @(posedge i_sclk or posedge i_chip_select_n) begin
		if (i_chip_select_n) begin
			shout_reg <= 16'h0000;
		end else if (cnt_reg == 5'h00) begin
			// first rise keeps the msb up; the shifts start at the second
			shout_reg <= i_reply;
		end else begin
			shout_reg <= shout_next;
		end
	end

	// first bit shows as soon as select falls, before any edge
	assign o_sdo = (cnt_reg == 5'h00) ? i_reply[15] : shout_reg[15];
	assign o_sdo_oe = ~i_chip_select_n;

	// frame end: word and count are captured as select rises
	always_ff @(posedge i_chip_select_n) begin
		o_word     <= shin_reg;
		o_count    <= cnt_reg;
	end
	// select level marks frame done; an unreset toggle would stay unknown
	assign o_done_tgl = i_chip_select_n;
endmodule : gdsfc_spi_link
`default_nettype wire

// ==== core/gdsfc_core.sv ====
// gate driver state sequencer, fault matrix and serial register core
`timescale 1ns/1ns
`default_nettype none
module gdsfc_core (
	// core clock and reset
	input  wire logic       i_core_clk,
	input  wire logic       i_rst,
	// supervisors and pins
	input  wire logic       i_sleep_pin_n,
	input  wire logic       i_logic_supply_ok,
	input  wire logic       i_power_rail_ok,
	input  wire logic       i_driver_off_pin,
	input  wire logic       i_hardwired,
	// fault monitors
	input  wire logic       i_thermal_shutdown,
	input  wire logic       i_thermal_warning,
	input  wire logic       i_mon_fault,
	input  wire logic [1:0] i_mon_mode,
	input  wire logic       i_pwm,
	// serial link
	input  wire logic       i_sclk,
	input  wire logic       i_chip_select_n,
	input  wire logic       i_sdi,
	output logic            o_sdo,
	output logic            o_sdo_oe,
	// driver and analog controls
	output logic            o_core_active,
	output logic            o_charge_pump_en,
	output logic            o_current_sense_en,
	output logic            o_gate_drive_en,
	output logic            o_gate_pulldown,
	output logic            o_semi_pulldown,
	output logic            o_passive_pulldown,
	output logic            o_fault_pin_n,
	output logic            o_frame_error,
	output logic [1:0]      o_state
);
	// synchronised pins
	logic [1:0] sl_s;
	logic [1:0] ls_s;
	logic [1:0] pr_s;
	logic [1:0] do_s;
	logic [1:0] ts_s;
	logic [1:0] tw_s;
	logic [1:0] mf_s;
	logic [1:0] pw_s;
	logic [1:0] hw_s;
	logic [2:0] dn_s;
	logic       pwm_d;

	// link side
	logic [15:0] link_word;
	logic [4:0]  link_count;
	logic        link_tgl;
	logic [15:0] reply_reg;
	logic [15:0] reply_next;

	// state
	gdsfc_pkg::gdsfc_state_t st_reg;
	gdsfc_pkg::gdsfc_state_t st_next;
	logic [7:0]  wake_reg;
	logic [7:0]  wake_next;
	logic [7:0]  ctrl_reg;
	logic [7:0]  ctrl_next;
	logic        thermal_shutdown_flag_reg;
	logic        thermal_shutdown_flag_next;
	logic        otw_reg;
	logic        otw_next;
	logic        mon_reg;
	logic        mon_next;
	logic        warn_reg;
	logic        warn_next;
	logic        flt_reg;
	logic        flt_next;
	logic        por_reg;
	logic        por_next;
	logic        ferr_reg;
	logic        ferr_next;

	logic frame_evt;
	logic frame_ok;
	logic clr_cmd;
	logic [7:0] stat1;
	logic [7:0] stat2;
	logic [7:0] rd_data;
	logic [5:0] addr;
	logic awake;
	logic pwm_rise;
	gdsfc_pkg::gdsfc_mode_t mode;

	// two-flop synchronisers for pins and link events
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			sl_s <= 2'h0;
			ls_s <= 2'h0;
			pr_s <= 2'h0;
			do_s <= 2'h0;
			ts_s <= 2'h0;
			tw_s <= 2'h0;
			mf_s <= 2'h0;
			pw_s <= 2'h0;
			hw_s <= 2'h0;
			dn_s <= 3'h7; // select idles high: no false edge
			pwm_d <= 1'b0;
		end else begin
			sl_s <= {sl_s[0], i_sleep_pin_n};
			ls_s <= {ls_s[0], i_logic_supply_ok};
			pr_s <= {pr_s[0], i_power_rail_ok};
			do_s <= {do_s[0], i_driver_off_pin};
			ts_s <= {ts_s[0], i_thermal_shutdown};
			tw_s <= {tw_s[0], i_thermal_warning};
			mf_s <= {mf_s[0], i_mon_fault};
			pw_s <= {pw_s[0], i_pwm};
			hw_s <= {hw_s[0], i_hardwired};
			dn_s <= {dn_s[1:0], link_tgl};
			pwm_d <= pw_s[1];
		end
	end

	// link logic on the serial clock
	gdsfc_spi_link u_link (
		.i_sclk          (i_sclk),
		.i_chip_select_n (i_chip_select_n),
		.i_sdi           (i_sdi),
		.o_sdo           (o_sdo),
		.o_sdo_oe        (o_sdo_oe),
		.i_reply         (reply_reg),
		.o_word          (link_word),
		.o_count         (link_count),
		.o_done_tgl      (link_tgl)
	);

	// frame decode on the synchronised select rise; word settled by then
	assign frame_evt = dn_s[1] && !dn_s[2];
	assign frame_ok  = frame_evt && (link_count == gdsfc_pkg::CNT_FULL)
		&& !link_word[gdsfc_pkg::TOP_BIT];
	assign addr = link_word[gdsfc_pkg::ADDR_HI:gdsfc_pkg::ADDR_LO];
	assign clr_cmd = frame_ok && !link_word[gdsfc_pkg::RW_BIT]
		&& (addr == gdsfc_pkg::ADDR_CTRL)
		&& link_word[gdsfc_pkg::CTRL_CLR_BIT];
	assign awake = (st_reg == gdsfc_pkg::GDSFC_STANDBY)
		|| (st_reg == gdsfc_pkg::GDSFC_OPERATE);
	assign pwm_rise = pw_s[1] && !pwm_d;
	assign mode = gdsfc_pkg::gdsfc_mode_t'(i_mon_mode);

	// status bytes: summary flags then detail flags
	assign stat1 = {1'b1, por_reg, flt_reg, warn_reg, mon_reg,
		~pr_s[1], 1'b0, thermal_shutdown_flag_reg | otw_reg};
	assign stat2 = {~pr_s[1], 2'b00, otw_reg, thermal_shutdown_flag_reg, 2'b00, ferr_reg};

	// register readback mux
	always_comb begin
		unique case (addr)
			gdsfc_pkg::ADDR_STAT1: rd_data = stat1;
			gdsfc_pkg::ADDR_STAT2: rd_data = stat2;
			gdsfc_pkg::ADDR_CTRL:  rd_data = ctrl_reg;
			default:               rd_data = 8'h00;
		endcase
	end

	// power state sequencer
	always_comb begin
		st_next   = st_reg;
		wake_next = wake_reg;
		unique case (st_reg)
			gdsfc_pkg::GDSFC_SLEEP: begin
				wake_next = 8'h00;
				if (sl_s[1] && ls_s[1]) begin
					st_next = gdsfc_pkg::GDSFC_WAKE;
				end
			end
			gdsfc_pkg::GDSFC_WAKE: begin
				wake_next = wake_reg + 8'h01;
				if (wake_reg == gdsfc_pkg::WAKE_CNT - 8'h01) begin
					st_next = gdsfc_pkg::GDSFC_STANDBY;
				end
			end
			gdsfc_pkg::GDSFC_STANDBY: begin
				if (pr_s[1]) begin
					st_next = gdsfc_pkg::GDSFC_OPERATE;
				end
			end
			gdsfc_pkg::GDSFC_OPERATE: begin
				if (!pr_s[1]) begin
					st_next = gdsfc_pkg::GDSFC_STANDBY;
				end
			end
		endcase
		if (!sl_s[1] || !ls_s[1]) begin
			st_next = gdsfc_pkg::GDSFC_SLEEP;
		end
	end

	// fault flags and control register; sets win over clear
	always_comb begin
		ctrl_next = ctrl_reg;
		thermal_shutdown_flag_next = thermal_shutdown_flag_reg;
		otw_next  = otw_reg;
		mon_next  = mon_reg;
		warn_next = warn_reg;
		flt_next  = flt_reg;
		por_next  = por_reg;
		ferr_next = ferr_reg;
		reply_next = reply_reg;
		if (frame_ok && !link_word[gdsfc_pkg::RW_BIT]
			&& addr == gdsfc_pkg::ADDR_CTRL) begin
			// clear bit is a self-clearing command
			ctrl_next = link_word[gdsfc_pkg::DATA_HI:0]
				& ~(8'h01 << gdsfc_pkg::CTRL_CLR_BIT);
		end
		if (clr_cmd) begin
			thermal_shutdown_flag_next = 1'b0;
			otw_next  = 1'b0;
			mon_next  = 1'b0;
			warn_next = 1'b0;
			flt_next  = 1'b0;
			por_next  = 1'b0;
			ferr_next = 1'b0;
		end
		if (pwm_rise && mode == gdsfc_pkg::GDSFC_CYCLE && !thermal_shutdown_flag_reg) begin
			flt_next = 1'b0;
		end
		if (frame_evt && !frame_ok) begin
			ferr_next = 1'b1;
		end
		if (awake) begin
			if (ts_s[1]) begin
				thermal_shutdown_flag_next = 1'b1;
				flt_next  = 1'b1;
			end
			if (tw_s[1]) begin
				otw_next  = 1'b1;
				warn_next = 1'b1;
			end
			if (mf_s[1]) begin
				unique case (mode)
					gdsfc_pkg::GDSFC_LATCHED,
					gdsfc_pkg::GDSFC_CYCLE: begin
						mon_next = 1'b1;
						flt_next = 1'b1;
					end
					gdsfc_pkg::GDSFC_WARN: begin
						mon_next  = 1'b1;
						warn_next = 1'b1;
					end
					gdsfc_pkg::GDSFC_DISABLED: begin
						mon_next = mon_reg;
					end
				endcase
			end
		end
		if (frame_evt) begin
			reply_next = {stat1, (link_word[gdsfc_pkg::RW_BIT] && frame_ok)
				? rd_data : 8'h00};
		end
		if (!ls_s[1]) begin
			ctrl_next = gdsfc_pkg::CTRL_RESET;
			thermal_shutdown_flag_next = 1'b0;
			otw_next  = 1'b0;
			mon_next  = 1'b0;
			warn_next = 1'b0;
			flt_next  = 1'b0;
			ferr_next = 1'b0;
			por_next  = 1'b1;
			reply_next = {stat1, 8'h00};
		end
	end

	// register all core state
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			st_reg   <= gdsfc_pkg::GDSFC_SLEEP;
			wake_reg <= 8'h00;
			ctrl_reg <= gdsfc_pkg::CTRL_RESET;
			thermal_shutdown_flag_reg <= 1'b0;
			otw_reg  <= 1'b0;
			mon_reg  <= 1'b0;
			warn_reg <= 1'b0;
			flt_reg  <= 1'b0;
			por_reg  <= 1'b1;
			ferr_reg <= 1'b0;
			reply_reg <= 16'h0000;
		end else begin
			st_reg   <= st_next;
			wake_reg <= wake_next;
			ctrl_reg <= ctrl_next;
			thermal_shutdown_flag_reg <= thermal_shutdown_flag_next;
			otw_reg  <= otw_next;
			mon_reg  <= mon_next;
			warn_reg <= warn_next;
			flt_reg  <= flt_next;
			por_reg  <= por_next;
			ferr_reg <= ferr_next;
			reply_reg <= reply_next;
		end
	end

	// output decode; por reply sits in reply_reg only, not the fault pin
	always_comb begin
		o_state            = st_reg;
		o_core_active      = awake;
		o_charge_pump_en   = (st_reg == gdsfc_pkg::GDSFC_OPERATE) && !thermal_shutdown_flag_reg;
		o_current_sense_en = o_charge_pump_en;
		o_gate_drive_en    = o_charge_pump_en && !flt_reg && !hw_s[1]
			? (ctrl_reg[gdsfc_pkg::CTRL_EN_BIT] && !do_s[1])
			: (o_charge_pump_en && !flt_reg && !do_s[1]);
		o_gate_pulldown    = awake && !o_gate_drive_en;
		o_semi_pulldown    = thermal_shutdown_flag_reg || (!ls_s[1] && sl_s[1]);
		o_passive_pulldown = !awake;
		o_fault_pin_n      = !flt_reg;
		o_frame_error      = ferr_reg;
	end
endmodule : gdsfc_core
`default_nettype wire

// ==== tb/gdsfc_sva.sv ====
// assertion checker for the gate driver control core
`timescale 1ns/1ns
`default_nettype none
module gdsfc_sva (
	// core clock and reset
	input wire logic       i_core_clk,
	input wire logic       i_rst,
	// watched inputs
	input wire logic       i_sleep_pin_n,
	input wire logic       i_logic_supply_ok,
	input wire logic       i_power_rail_ok,
	input wire logic       i_driver_off_pin,
	input wire logic       i_thermal_shutdown,
	input wire logic       i_chip_select_n,
	// watched outputs
	input wire logic       o_sdo_oe,
	input wire logic       o_core_active,
	input wire logic       o_charge_pump_en,
	input wire logic       o_current_sense_en,
	input wire logic       o_gate_drive_en,
	input wire logic       o_semi_pulldown,
	input wire logic       o_passive_pulldown,
	input wire logic       o_fault_pin_n,
	input wire logic [1:0] o_state
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	// cycles spent in the wake state
	logic [7:0] wake_cnt_reg;
	logic [7:0] wake_cnt_next;
	always_comb begin
		wake_cnt_next = (o_state == 2'h1) ? wake_cnt_reg + 8'h01 : 8'h00;
	end
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			wake_cnt_reg <= 8'h00;
		end else begin
			wake_cnt_reg <= wake_cnt_next;
		end
	end
	sequence s_standby_ready;
		o_state == 2'h2 && i_sleep_pin_n && i_logic_supply_ok && i_power_rail_ok;
	endsequence
	sequence s_operating;
		o_state == 2'h3;
	endsequence
	property p_sleep_pin;
		!i_sleep_pin_n [*5] |-> o_state == 2'h0 && o_passive_pulldown;
	endproperty
	property p_sleep_off;
		o_state == 2'h0 |-> o_passive_pulldown && !o_gate_drive_en;
	endproperty
	// wake delay is about one microsecond, never skipped
	property p_wake_delay;
		($past(o_state) == 2'h1 && o_state[1]) |-> wake_cnt_reg inside {[8'h60:8'h68]};
	endproperty
	property p_standby;
		o_state == 2'h2 |-> o_core_active && !o_charge_pump_en && !o_gate_drive_en;
	endproperty
	property p_operate;
		s_standby_ready [*3] |-> ##[0:6] s_operating;
	endproperty
	property p_drive_gate;
		o_gate_drive_en |-> o_state == 2'h3 && o_fault_pin_n;
	endproperty
	property p_sdo_hiz;
		o_sdo_oe == !i_chip_select_n;
	endproperty
	property p_thermal;
		o_core_active && $rose(i_thermal_shutdown) |-> ##[1:4] (!o_fault_pin_n
			&& o_semi_pulldown && !o_charge_pump_en && !o_current_sense_en);
	endproperty
	property p_drv_off;
		i_driver_off_pin [*4] |-> !o_gate_drive_en;
	endproperty
	property p_supply_reset;
		!i_logic_supply_ok [*5] |-> o_state == 2'h0 && o_semi_pulldown;
	endproperty
	a_sleep_pin: assert property (p_sleep_pin)
		else $error("awake while sleep pin low");
	a_sleep_off: assert property (p_sleep_off)
		else $error("gates not held off while asleep");
	a_wake_delay: assert property (p_wake_delay)
		else $error("wake delay length wrong");
	a_standby: assert property (p_standby)
		else $error("standby drives pump or gates");
	a_operate: assert property (p_operate)
		else $error("operating state not entered");
	a_drive_gate: assert property (p_drive_gate)
		else $error("gate drive outside operating state");
	a_sdo_hiz: assert property (p_sdo_hiz)
		else $error("serial output enable wrong");
	a_thermal: assert property (p_thermal)
		else $error("thermal shutdown response missing");
	a_drv_off: assert property (p_drv_off)
		else $error("drivers on while driver off pin high");
	a_supply_reset: assert property (p_supply_reset)
		else $error("supply reset response missing");
endmodule : gdsfc_sva
bind gdsfc_core gdsfc_sva i_gdsfc_sva (.i_core_clk(i_core_clk), .i_rst(i_rst),
	.i_sleep_pin_n(i_sleep_pin_n), .i_logic_supply_ok(i_logic_supply_ok),
	.i_power_rail_ok(i_power_rail_ok), .i_driver_off_pin(i_driver_off_pin),
	.i_thermal_shutdown(i_thermal_shutdown), .i_chip_select_n(i_chip_select_n),
	.o_sdo_oe(o_sdo_oe), .o_core_active(o_core_active),
	.o_charge_pump_en(o_charge_pump_en), .o_current_sense_en(o_current_sense_en),
	.o_gate_drive_en(o_gate_drive_en), .o_semi_pulldown(o_semi_pulldown),
	.o_passive_pulldown(o_passive_pulldown), .o_fault_pin_n(o_fault_pin_n),
	.o_state(o_state));
`default_nettype wire

// ==== tb/gdsfc_master.sv ====
// serial master model driving frames on its own link clock
`timescale 1ns/1ns
`default_nettype none
module gdsfc_master (
	// frame request from the bench
	input  wire logic        i_go,
	input  wire logic [15:0] i_word,
	input  wire logic [4:0]  i_nbits,
	// serial pins
	input  wire logic        i_sdo,
	output logic             o_sclk,
	output logic             o_chip_select_n,
	output logic             o_sdi,
	// reply and progress
	output logic [15:0]      o_reply,
	output logic             o_busy
);
	// idle: select high, clock parked low
	// a short select pulse at start clears the unreset link counter
	initial begin
		o_sclk = 1'b0;
		o_chip_select_n = 1'b0;
		o_sdi = 1'b0;
		o_reply = 16'h0000;
		o_busy = 1'b0;
		#1;
		o_chip_select_n = 1'b1;
	end
	// 80 ns link clock runs only inside a frame
	always @(posedge i_go) begin : frame
		int i;
		o_busy = 1'b1;
		#3;
		o_chip_select_n = 1'b0;
		for (i = 0; i < int'(i_nbits); i++) begin
			#40;
			o_sclk = 1'b1;
			o_sdi = (i < 16) ? i_word[4'(15 - i)] : 1'b0;
			#40;
			o_sclk = 1'b0;
			o_reply = {o_reply[14:0], i_sdo};
		end
		#40;
		// select up after the counted clocks
		o_chip_select_n = 1'b1;
		// released line shows the inverse, not a held bit
		o_sdi = ~o_sdi;
		#100;
		o_busy = 1'b0;
	end
endmodule : gdsfc_master
`default_nettype wire

// ==== tb/testbench.sv ====
// self-checking bench for the gate driver control core
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic clk = 1'b0, rst = 1'b1, sleep_n = 1'b0, sup = 1'b1, rail = 1'b1;
	logic drv_off = 1'b0, hw = 1'b1, tsd = 1'b0, mon = 1'b0, pwm = 1'b0;
	logic go = 1'b0;
	logic [1:0] mode = 2'h0;
	logic [15:0] word = 16'h0000;
	logic [4:0] nbits = 5'h10;
	wire logic sclk, cs_n, sdi, sdo, busy, act, pump, sense, gate, semi, pas;
	wire logic flt_n, ferr, gpd;
	wire logic [1:0] st;
	wire logic [15:0] reply;
	int failures = 0, n_checks = 0, r;
	// rows: {sleep_n, supply, rail, hw} then {state, gate, pump}
	localparam logic [7:0] ROWS [5] = '{8'h70, 8'hD8, 8'hFF, 8'hB0, 8'hED};
	always #5 clk = ~clk;
	gdsfc_core i_gdsfc_core (.i_core_clk(clk), .i_rst(rst),
		.i_sleep_pin_n(sleep_n), .i_logic_supply_ok(sup), .i_power_rail_ok(rail),
		.i_driver_off_pin(drv_off), .i_hardwired(hw), .i_thermal_shutdown(tsd),
		.i_thermal_warning(1'b0), .i_mon_fault(mon), .i_mon_mode(mode),
		.i_pwm(pwm), .i_sclk(sclk), .i_chip_select_n(cs_n), .i_sdi(sdi),
		.o_sdo(sdo), .o_sdo_oe(), .o_core_active(act), .o_charge_pump_en(pump),
		.o_current_sense_en(sense), .o_gate_drive_en(gate),
		.o_gate_pulldown(gpd),
		.o_semi_pulldown(semi), .o_passive_pulldown(pas), .o_fault_pin_n(flt_n),
		.o_frame_error(ferr), .o_state(st));
	gdsfc_master i_gdsfc_master (.i_go(go), .i_word(word), .i_nbits(nbits),
		.i_sdo(sdo), .o_sclk(sclk), .o_chip_select_n(cs_n), .o_sdi(sdi),
		.o_reply(reply), .o_busy(busy));
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic summarize;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : summarize
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	// one frame through the master, bounded wait for its end
	task automatic frame(input logic [15:0] w, input logic [4:0] n);
		int k;
		k = 0;
		@(posedge clk);
		word <= w;
		nbits <= n;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		while (busy && k < 300) begin
			@(posedge clk);
			k++;
		end
		if (k >= 300) begin
			failures++;
			summarize();
		end
	endtask : frame
	initial begin
		cyc(10);
		rst <= 1'b0;
		cyc(4);
		// pin driven states
		for (r = 0; r < 5; r++) begin
			@(posedge clk);
			{sleep_n, sup, rail, hw} <= ROWS[r][7:4];
			cyc(150);
			chk(16'({st, gate, pump}), 16'(ROWS[r][3:0]));
		end
		// serial writes, reads and one-frame reply pipeline
		frame(16'h0000, 5'h10);
		frame(16'h0480, 5'h10);
		chk(16'(gate), 16'h0001);
		frame(16'h4480, 5'h10);
		chk(reply & 16'h80FF, 16'h8000);
		frame(16'h0480, 5'h10);
		chk({reply[7:0], 7'h00, ferr}, 16'h8000);
		// short, long and top-bit-set frames are refused
		for (r = 0; r < 3; r++) begin
			// the long and top-bit words would clear the enable bit if taken; the short one would land on stat2
			frame((r == 0) ? 16'h0400 : (r == 1) ? 16'h0200 : 16'h8400,
				(r == 1) ? 5'h11 : (r == 0) ? 5'h0F : 5'h10);
			chk(16'({ferr, gate}), 16'h0003);
			frame(16'h0481, 5'h10);
			chk(16'(ferr), 16'h0000);
		end
		// driver off pin keeps core and pump alive
		@(posedge clk);
		drv_off <= 1'b1;
		cyc(8);
		chk(16'({gate, act, pump, gpd}), 16'h0007);
		drv_off <= 1'b0;
		cyc(8);
		chk(16'(gate), 16'h0001);
		// thermal shutdown latches until cleared
		tsd <= 1'b1;
		cyc(8);
		chk(16'({flt_n, semi, pump, sense, gate}), 16'h0008);
		tsd <= 1'b0;
		cyc(8);
		chk(16'({flt_n, gate}), 16'h0000);
		frame(16'h4200, 5'h10);
		frame(16'h0481, 5'h10);
		chk(16'(reply[3]), 16'h0001);
		chk(16'({flt_n, gate, pump}), 16'h0007);
		// every monitor mode, then a pwm edge and a clear
		for (r = 0; r < 4; r++) begin
			@(posedge clk);
			mode <= 2'(r);
			mon <= 1'b1;
			cyc(8);
			mon <= 1'b0;
			cyc(8);
			chk(16'({flt_n, gate}), (r >= 2) ? 16'h0003 : 16'h0000);
			pwm <= 1'b1;
			cyc(8);
			pwm <= 1'b0;
			cyc(8);
			chk(16'({flt_n, gate}), (r == 0) ? 16'h0000 : 16'h0003);
			frame(16'h0481, 5'h10);
		end
		// logic supply drop, then a reset in mid-run
		@(posedge clk);
		sup <= 1'b0;
		cyc(8);
		chk(16'({st, semi, pump}), 16'h0002);
		rst <= 1'b1;
		cyc(2);
		chk(16'({st, pas, flt_n}), 16'h0003);
		// release in mid-run: wakes to operate with the enable bit cleared
		rst <= 1'b0;
		sup <= 1'b1;
		cyc(150);
		chk(16'({st, gate, pump, flt_n}), 16'h001B);
		frame(16'h0480, 5'h10);
		chk(16'(gate), 16'h0001);
		summarize();
	end
endmodule : testbench
`default_nettype wire
